// [hdl/clock_startup_pkg.sv]
// Constants, field layouts and carrier types for the oscillator start-up selector.
package clock_startup_pkg;
   // ==========================================================================
   // Clock source and start-up encodings
   // ==========================================================================
   localparam logic [3:0] SRC_RC_OSC = 4'h2;
   localparam logic [3:0] SRC_LP_OSC = 4'h3;
   localparam logic [1:0] SUT_14CK = 2'h0;
   localparam logic [1:0] SUT_4MS = 2'h1;
   localparam logic [1:0] SUT_65MS = 2'h2;
   localparam logic [1:0] SUT_RESERVED = 2'h3;
   localparam logic [3:0] SHIPPED_SRC = SRC_RC_OSC;
   localparam logic [1:0] SHIPPED_SUT = SUT_65MS;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CNT_W = 21;
   localparam logic [CNT_W-1:0] WAKE_CK = 21'h000006;
   localparam logic [CNT_W-1:0] RESET_CK = 21'h00000E;
   localparam logic [CNT_W-1:0] SYNC_FILL = 21'h000002;
   localparam logic [2:0] DIV_LAST = 3'h7;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned T_4MS_NS = 4100000;
   localparam int unsigned T_65MS_NS = 65000000;
   localparam int unsigned T_4MS_CYCLES = (T_4MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_65MS_CYCLES = (T_65MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [3:0] ADDR_CLKSEL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned SUT_LSB = 4;
   localparam int unsigned APPLY_BIT = 7;
   localparam int unsigned DIV_BIT = 6;
   localparam int unsigned RUN_BIT = 7;

   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_fuse_code;
   } clk_sel_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] src;
      logic [1:0] startup_fuse_code;
      logic div8;
      logic rst_pin_dis;
   } fuse_t;
endpackage : clock_startup_pkg

// [hdl/osc_prescale.sv]
// Optional divide-by-eight prescaler on the selected oscillator tick.
`timescale 1ns/1ps
`default_nettype none
module osc_prescale
   import clock_startup_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic en_i,
   input wire logic tick_i,
   input wire logic div8_i,
   output logic tick_o
);
   logic [2:0] div_cnt_ff;
   logic tick_ff;
   wire logic wrap = (div_cnt_ff == DIV_LAST);
   wire logic [2:0] nxt_div_cnt = wrap ? 3'h0 : div_cnt_ff + 3'h1;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         div_cnt_ff <= 3'h0;
         tick_ff <= 1'b0;
      end else if (en_i) begin
         if (tick_i) begin
            div_cnt_ff <= nxt_div_cnt;
         end
         tick_ff <= tick_i && (!div8_i || wrap);
      end
   end

   assign tick_o = tick_ff;
endmodule : osc_prescale
`default_nettype wire

// [hdl/osc_startup_select.sv]
// Oscillator selection, start-up delay sequencing and clock gating.
`timescale 1ns/1ps
`default_nettype none
module osc_startup_select
   import clock_startup_pkg::*;
#(
   parameter int unsigned DELAY_4MS_CYCLES = T_4MS_CYCLES,
   parameter int unsigned DELAY_65MS_CYCLES = T_65MS_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic en_i,
   input wire logic rc_osc_tick_i,
   input wire logic lp_osc_tick_i,
   input wire fuse_t fuse_i,
   input wire logic sleep_req_i,
   input wire logic wake_i,
   input wire reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic rc_osc_en_o,
   output logic lp_osc_en_o,
   output logic sys_clk_en_o,
   output logic sys_tick_o,
   output clk_sel_t active_sel_o
);
   // ==========================================================================
   // Validation helpers
   // ==========================================================================
   function automatic logic src_ok(input logic [3:0] src);
      src_ok = (src == SRC_RC_OSC) || (src == SRC_LP_OSC);
   endfunction : src_ok

   function automatic logic sut_ok(input logic [1:0] startup_fuse_code, input logic rst_dis);
      sut_ok = (startup_fuse_code != SUT_RESERVED) && !((startup_fuse_code == SUT_14CK) && rst_dis);
   endfunction : sut_ok

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   localparam int unsigned NPIN = 10;
   wire logic [NPIN-1:0] pin_raw = {rc_osc_tick_i, lp_osc_tick_i, fuse_i};
   logic [NPIN-1:0] meta_ff;
   logic [NPIN-1:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < NPIN; g = g + 1) begin : g_sync
         always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
               meta_ff[g] <= 1'b0;
               sync_ff[g] <= 1'b0;
            end else if (en_i) begin
               meta_ff[g] <= pin_raw[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   localparam int unsigned RC_PIN = 9;
   localparam int unsigned LP_PIN = 8;
   localparam int unsigned FUSE_W = 8;
   wire fuse_t fuse_s = sync_ff[FUSE_W-1:0];
   wire logic rc_lvl = sync_ff[RC_PIN];
   wire logic lp_lvl = sync_ff[LP_PIN];
   logic rc_old_ff;
   logic lp_old_ff;
   wire logic rc_tick = rc_lvl && !rc_old_ff;
   wire logic lp_tick = lp_lvl && !lp_old_ff;

   // ==========================================================================
   // State
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_LOAD,
      ST_WAIT_MS,
      ST_WAIT_CK,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE
   } state_t;

   state_t state_ff;
   state_t nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   clk_sel_t active_ff;
   clk_sel_t nxt_active;
   clk_sel_t regsel_ff;
   clk_sel_t nxt_regsel;
   logic div8_ff;
   logic [7:0] rdata_ff;

   localparam logic [CNT_W-1:0] LIM_4MS = CNT_W'(DELAY_4MS_CYCLES - 1);
   localparam logic [CNT_W-1:0] LIM_65MS = CNT_W'(DELAY_65MS_CYCLES - 1);

   // Fuse copy with invalid codes replaced by the delivery defaults.
   wire logic [3:0] fuse_src = src_ok(fuse_s.src) ? fuse_s.src : SHIPPED_SRC;
   wire logic [1:0] fuse_sut =
      sut_ok(fuse_s.startup_fuse_code, fuse_s.rst_pin_dis) ? fuse_s.startup_fuse_code : SHIPPED_SUT;
   wire clk_sel_t fuse_sel = '{src: fuse_src, startup_fuse_code: fuse_sut};

   // Selected oscillator tick; the clock-count and wake delays count oscillator cycles, the ms delay counts core clock cycles.
   wire logic sel_is_lp = (active_ff.src == SRC_LP_OSC);
   wire logic osc_tick = sel_is_lp ? lp_tick : rc_tick;
   wire logic ms_done =
      (active_ff.startup_fuse_code == SUT_4MS) ? (cnt_ff >= LIM_4MS) : (cnt_ff >= LIM_65MS);
   wire logic ck_done = osc_tick && (cnt_ff == RESET_CK - 21'h1);
   wire logic wake_done = osc_tick && (cnt_ff == WAKE_CK - 21'h1);

   // ==========================================================================
   // Register bus decode
   // ==========================================================================
   wire logic hit_clksel = (req_i.addr == ADDR_CLKSEL);
   wire logic hit_status = (req_i.addr == ADDR_STATUS);
   wire logic wr_clksel = req_i.wr && hit_clksel;
   wire logic [3:0] wr_src = req_i.wdata[SRC_LSB +: 4];
   wire logic [1:0] wr_sut = req_i.wdata[SUT_LSB +: 2];
   wire logic apply = wr_clksel && req_i.wdata[APPLY_BIT] && (state_ff == ST_RUN);
   wire logic [7:0] rd_clksel = {2'h0, regsel_ff.startup_fuse_code, regsel_ff.src};
   wire logic [7:0] rd_status =
      {(state_ff == ST_RUN), div8_ff, active_ff.startup_fuse_code, active_ff.src};
   logic [7:0] rd_mux;

   // Unmapped addresses read as zero so software can probe the map safely.
   always_comb begin
      if (hit_clksel) begin
         rd_mux = rd_clksel;
      end else if (hit_status) begin
         rd_mux = rd_status;
      end else begin
         rd_mux = 8'h00;
      end
   end

   // Refused codes leave the stored field unchanged.
   always_comb begin
      nxt_regsel = regsel_ff;
      if (wr_clksel) begin
         if (src_ok(wr_src)) begin
            nxt_regsel.src = wr_src;
         end
         if (sut_ok(wr_sut, fuse_s.rst_pin_dis)) begin
            nxt_regsel.startup_fuse_code = wr_sut;
         end
      end
   end

   // ==========================================================================
   // Start-up sequencer
   // ==========================================================================
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_active = active_ff;
      case (state_ff)
         ST_LOAD: begin
            // Wait for the fuse synchronisers to fill before trusting them.
            nxt_cnt = cnt_ff + 21'h1;
            if (cnt_ff == SYNC_FILL) begin
               nxt_active = fuse_sel;
               nxt_cnt = '0;
               nxt_state = (fuse_sut == SUT_14CK) ? ST_WAIT_CK : ST_WAIT_MS;
            end
         end
         ST_WAIT_MS: begin
            nxt_cnt = cnt_ff + 21'h1;
            if (ms_done) begin
               nxt_cnt = '0;
               nxt_state = ST_WAIT_CK;
            end
         end
         ST_WAIT_CK: begin
            if (osc_tick) begin
               nxt_cnt = cnt_ff + 21'h1;
            end
            if (ck_done) begin
               nxt_cnt = '0;
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (apply) begin
               // A run-time switch replays the reset delay of the new code.
               nxt_active = nxt_regsel;
               nxt_cnt = '0;
               nxt_state = (nxt_regsel.startup_fuse_code == SUT_14CK) ? ST_WAIT_CK : ST_WAIT_MS;
            end else if (sleep_req_i) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            nxt_cnt = '0;
            if (wake_i) begin
               nxt_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (osc_tick) begin
               nxt_cnt = cnt_ff + 21'h1;
            end
            if (wake_done) begin
               nxt_cnt = '0;
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_LOAD;
            nxt_cnt = '0;
         end
      endcase
   end

   // ==========================================================================
   // Registers
   // ==========================================================================
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_ff <= ST_LOAD;
         cnt_ff <= '0;
      end else if (en_i) begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Both copies start at the delivery defaults; only the active copy takes the fuse values once they are trusted.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         active_ff <= '{src: SHIPPED_SRC, startup_fuse_code: SHIPPED_SUT};
         regsel_ff <= '{src: SHIPPED_SRC, startup_fuse_code: SHIPPED_SUT};
      end else if (en_i) begin
         active_ff <= nxt_active;
         regsel_ff <= nxt_regsel;
      end
   end

   // The old levels reset low, the idle level of a stopped oscillator pin.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rc_old_ff <= 1'b0;
         lp_old_ff <= 1'b0;
      end else if (en_i) begin
         rc_old_ff <= rc_lvl;
         lp_old_ff <= lp_lvl;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         div8_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else if (en_i) begin
         if (state_ff == ST_LOAD) begin
            div8_ff <= fuse_s.div8;
         end
         if (req_i.rd) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   wire logic run = (state_ff == ST_RUN);
   wire logic osc_on = (state_ff != ST_SLEEP) && (state_ff != ST_LOAD);
   wire logic pre_tick;

   osc_prescale u_prescale (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .en_i(en_i),
      .tick_i(osc_tick && run),
      .div8_i(div8_ff),
      .tick_o(pre_tick)
   );

   // The oscillator is stopped in sleep and restarted before the wake count.
   assign rc_osc_en_o = osc_on && !sel_is_lp;
   assign lp_osc_en_o = osc_on && sel_is_lp;
   assign sys_clk_en_o = run;
   assign sys_tick_o = pre_tick && run;
   assign active_sel_o = active_ff;
   assign rdata_o = rdata_ff;
endmodule : osc_startup_select
`default_nettype wire

// [testbench/osc_startup_select_assertions.sv]
// Property checker for the oscillator start-up selector.
`timescale 1ns/1ps
`default_nettype none
module osc_startup_select_assertions
   import clock_startup_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic en_i,
   input wire fuse_t fuse_i,
   input wire logic sleep_req_i,
   input wire reg_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic rc_osc_en_o,
   input wire logic lp_osc_en_o,
   input wire logic sys_clk_en_o,
   input wire logic sys_tick_o,
   input wire clk_sel_t active_sel_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);
   // ==========================================================================
   // Decodes
   // ==========================================================================
   wire logic apply_w = en_i && req_i.wr && req_i.addr == ADDR_CLKSEL && req_i.wdata[APPLY_BIT];
   wire logic src_ok = req_i.wdata[3:0] == SRC_RC_OSC || req_i.wdata[3:0] == SRC_LP_OSC;
   wire logic sut_ok = req_i.wdata[5:4] == SUT_4MS || req_i.wdata[5:4] == SUT_65MS;
   sequence s_apply_ok;
      sys_clk_en_o && apply_w && src_ok && sut_ok;
   endsequence
   // ==========================================================================
   // Properties
   // ==========================================================================
   a_reset_vals: assert property (disable iff (1'b0) reset_i && en_i |=>
      active_sel_o == {SRC_RC_OSC, SHIPPED_SUT} && !sys_clk_en_o && rdata_o == 8'h00)
      else $error("reset values wrong");
   a_apply_drop: assert property (s_apply_ok |=> !sys_clk_en_o)
      else $error("apply did not gate clock");
   a_apply_load: assert property (s_apply_ok |=>
      active_sel_o == {$past(req_i.wdata[3:0]), $past(req_i.wdata[5:4])})
      else $error("apply did not load selection");
   a_sut_reserved: assert property (sys_clk_en_o && apply_w &&
      req_i.wdata[5:4] == SUT_RESERVED |=> $stable(active_sel_o.startup_fuse_code))
      else $error("reserved code accepted");
   a_sut0_locked: assert property (sys_clk_en_o && apply_w && fuse_i.rst_pin_dis &&
      req_i.wdata[5:4] == SUT_14CK |=> $stable(active_sel_o.startup_fuse_code))
      else $error("short code accepted");
   a_sleep_gate: assert property (sys_clk_en_o && en_i && sleep_req_i && !apply_w
      |=> !sys_clk_en_o)
      else $error("sleep did not gate clock");
   a_off_hold: assert property ($fell(sys_clk_en_o) |-> !sys_clk_en_o [*8])
      else $error("clock released too early");
   a_osc_on: assert property (sys_clk_en_o |->
      (active_sel_o.src == SRC_LP_OSC ? lp_osc_en_o : rc_osc_en_o))
      else $error("selected oscillator off");
   a_tick_gated: assert property (!sys_clk_en_o && !$past(sys_clk_en_o) |-> !sys_tick_o)
      else $error("tick while gated");
endmodule : osc_startup_select_assertions
bind osc_startup_select osc_startup_select_assertions i_chk (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .en_i(en_i), .fuse_i(fuse_i), .sleep_req_i(sleep_req_i),
   .req_i(req_i), .rdata_o(rdata_o), .rc_osc_en_o(rc_osc_en_o), .lp_osc_en_o(lp_osc_en_o),
   .sys_clk_en_o(sys_clk_en_o), .sys_tick_o(sys_tick_o), .active_sel_o(active_sel_o));
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the oscillator start-up selector.
`timescale 1ns/1ps
`default_nettype none
module tb_top import clock_startup_pkg::*;;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic en_i = 1'b1;
   logic rc_pin = 1'b0;
   logic lp_pin = 1'b0;
   fuse_t fuse = '0;
   logic sleep_req = 1'b0;
   logic wake = 1'b0;
   reg_req_t req = '0;
   logic [7:0] rdata;
   logic rc_en, lp_en, clk_en, tick;
   clk_sel_t act;
   logic [7:0] exp_q[$];
   logic rd_q = 1'b0;
   logic [31:0] seed = 32'hACBB;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   int ticks = 0;
   int n;
   int t0;
   always #25 core_clk_i = ~core_clk_i;
   // Short delay parameters keep the run small; bounds below use 20 and 40.
   osc_startup_select #(.DELAY_4MS_CYCLES(20), .DELAY_65MS_CYCLES(40)) i_osc_startup_select (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .en_i(en_i), .rc_osc_tick_i(rc_pin),
      .lp_osc_tick_i(lp_pin), .fuse_i(fuse), .sleep_req_i(sleep_req), .wake_i(wake),
      .req_i(req), .rdata_o(rdata), .rc_osc_en_o(rc_en), .lp_osc_en_o(lp_en),
      .sys_clk_en_o(clk_en), .sys_tick_o(tick), .active_sel_o(act));
   // ==========================================================================
   // Oscillators, timeout and read monitor
   // ==========================================================================
   // A disabled oscillator holds its pin low, as a stopped one would.
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      rc_pin <= rc_en && (cyc % 4 < 2);
      lp_pin <= lp_en && (cyc % 6 < 3);
      ticks <= ticks + int'(tick);
      if (cyc == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   always @(posedge core_clk_i) begin
      if (rd_q) chk(rdata, exp_q.pop_front());
      rd_q <= req.rd;
   end
   // ==========================================================================
   // Tasks
   // ==========================================================================
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("Error %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
      @(posedge core_clk_i);
      req <= '{a, d, w, ~w};
      @(posedge core_clk_i);
      req <= '0;
   endtask : bus
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      bus(a, 8'h00, 1'b0);
      @(posedge core_clk_i);
   endtask : rd_reg
   task automatic wait_run(input int lo, input int hi);
      #1;
      n = 0;
      while (clk_en !== 1'b1 && n < 3000) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      chk({7'h00, n >= lo && n <= hi}, 8'h01);
   endtask : wait_run
   task automatic do_reset(input fuse_t f);
      @(posedge core_clk_i);
      fuse <= f;
      reset_i <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
   endtask : do_reset
   task automatic stop_test;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      do_reset('{SRC_RC_OSC, SUT_14CK, 1'b0, 1'b0});
      wait_run(50, 75);
      chk({2'h0, act}, 8'h08);
      rd_reg(ADDR_STATUS, 8'h82);
      bus(ADDR_CLKSEL, 8'h93, 1'b1);
      wait_run(100, 125);
      chk({6'h00, lp_en, rc_en}, 8'h02);
      rd_reg(ADDR_STATUS, 8'h93);
      bus(ADDR_CLKSEL, 8'hA2, 1'b1);
      wait_run(92, 115);
      bus(ADDR_CLKSEL, 8'hB2, 1'b1);
      wait_run(92, 115);
      rd_reg(ADDR_STATUS, 8'hA2);
      rd_reg(ADDR_CLKSEL, 8'h22);
      seed = lfsr(seed);
      rd_reg(4'h2 + 4'(seed % 14), 8'h00);
      sleep_req <= 1'b1;
      @(posedge core_clk_i);
      sleep_req <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      #1;
      chk({7'h00, clk_en}, 8'h00);
      @(posedge core_clk_i);
      wake <= 1'b1;
      @(posedge core_clk_i);
      wake <= 1'b0;
      wait_run(18, 36);
      // Second reset mid-run: short code with the reset pin disabled falls back to the long one.
      do_reset('{SRC_RC_OSC, SUT_14CK, 1'b1, 1'b1});
      wait_run(92, 120);
      rd_reg(ADDR_STATUS, 8'hE2);
      t0 = ticks;
      repeat (320) @(posedge core_clk_i);
      chk({7'h00, ticks - t0 >= 9 && ticks - t0 <= 11}, 8'h01);
      bus(ADDR_CLKSEL, 8'h82, 1'b1);
      wait_run(92, 115);
      rd_reg(ADDR_STATUS, 8'hE2);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
